// >>> tb/sadc_ain_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Analog pins and external trigger source
// ****************************************
module sadc_ain_model (
  input  wire logic       clk,
  input  wire logic [4:0] ain_select,
  input  wire logic       fire,
  output logic            ext_trigger_pin,
  output logic      [9:0] conv_data
);
  logic [2:0] low_q = 3'h0;
  // Held low for several cycles so the edge survives the synchroniser
  always @(posedge clk) begin
    low_q <= fire ? 3'h5 : (low_q != 3'h0 ? low_q - 3'h1 : 3'h0);
  end
  assign ext_trigger_pin = (low_q == 3'h0);
  // Level depends on the selected pin, so a wrong selection shows up
  assign conv_data = {ain_select, ~ain_select};
endmodule : sadc_ain_model
`default_nettype wire

// >>> tb/sadc_oneshot_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_oneshot_tb;
  // ****************************************
  // Signals and design
  // ****************************************
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0;
  logic [13:0] addr = 14'h0;
  logic [31:0] wdata = 32'h0, rdata, v, rs = 32'd37;
  logic [4:0]  ain_select;
  logic [9:0]  conv_data, e;
  logic        trig, she, cke, sstb, vref, conv_irq;
  int          failures = 0, n_compared = 0, cyc = 0, t0, lim;
  int          tick_total = 0, tk0;
  int          res_m[8] = '{default: 0};
  logic [9:0]  exp_q[$];
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (cke === 1'b1) tick_total <= tick_total + 1;
  sadc_oneshot dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ext_trigger_pin(trig), .conv_data(conv_data),
    .ain_select(ain_select), .sample_hold_enable(she), .conv_clk_en(cke),
    .sample_strobe(sstb), .vref_connect(vref), .conv_irq(conv_irq));
  sadc_ain_model far_u (.clk(clk), .ain_select(ain_select), .fire(fire),
    .ext_trigger_pin(trig), .conv_data(conv_data));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  function automatic int divf(logic [2:0] c);
    case (c)
      3'h0: return 4;
      3'h1: return 2;
      3'h4: return 12;
      3'h5: return 6;
      3'h6, 3'h7: return 3;
      default: return 1;
    endcase
  endfunction : divf
  task automatic chk_reg(string nm, logic [31:0] x, logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("wrong value %0s exp %h got %h", nm, x, g);
    end
  endtask : chk_reg
  task automatic chk_time(string nm, int lo, int hi, int g);
    n_compared++;
    if (g < lo || g > hi) begin
      failures++;
      $display("wrong value %0s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chk_time
  task automatic wr_reg(logic [13:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [13:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg
  task automatic wait_irq(int n);
    lim = 0;
    while (conv_irq !== 1'b1 && lim < n) begin
      @(negedge clk);
      lim++;
    end
  endtask : wait_irq
  task automatic conv(logic [2:0] k, logic ext);
    logic [2:0] ch;
    logic [1:0] g, opa;
    logic [4:0] pin;
    logic       sh, b10;
    int         len, d;
    v = xs();
    ch = v[2:0];
    g = v[4] ? 2'b11 : {v[3], 1'b0};
    sh = v[5];
    b10 = v[6];
    // Op-amp mode (code 11) lies outside this block: fold it to plain pins
    opa = (v[10:9] == 2'b11) ? 2'b00 : v[10:9];
    pin = (opa == sadc_pkg::OPA_EX0) ? sadc_pkg::AIN_EX0 :
          (opa == sadc_pkg::OPA_EX1) ? sadc_pkg::AIN_EX1 : {g, ch};
    len = sh ? (b10 ? 33 : 28) : (b10 ? 59 : 49);
    d = divf(k);
    wr_reg(sadc_pkg::CTRL2_ADDR, {27'h0, k[2], 1'b0, g, sh});
    // Sweep bits random and ignored; extended mode bit kept 0
    wr_reg(sadc_pkg::CTRL1_ADDR, {24'h0, opa, 1'b1, k[1], b10, 1'b0, v[8:7]});
    // Mode stays one-shot throughout, so no channel rewrite is owed
    wr_reg(sadc_pkg::CTRL0_ADDR, {24'h0, k[0], 1'b1, ext, 2'b00, ch});
    t0 = cyc;
    tk0 = tick_total;
    if (ext) begin
      // Second edge lands mid-conversion and must restart it
      repeat (2) begin
        repeat (12) @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        t0 = cyc;
      end
    end
    rd_reg(sadc_pkg::CTRL0_ADDR);
    chk_reg("flag busy", 1, v[6]);
    chk_reg("sample hold", sh, she);
    chk_reg("vref", 1, vref);
    // No control write until the conversion is over
    wait_irq(2000);
    chk_time("conv cycles", len * d - 1, len * d + d + (ext ? 9 : 3), cyc - t0);
    if (!ext) chk_time("conv ticks", len, len, tick_total - tk0);
    chk_reg("strobe", 1, sstb);
    chk_reg("ain select", pin, ain_select);
    e = {pin, ~pin};
    res_m[ch] = b10 ? int'(e) : int'(e[9:2]);
    exp_q.push_back(10'(res_m[ch]));
    rd_reg(sadc_pkg::RESULT_ADDR + {9'h0, ch, 2'b00});
    chk_reg("result", 32'(exp_q.pop_front()), v);
    rd_reg(sadc_pkg::CTRL0_ADDR);
    chk_reg("flag after", ext, v[6]);
    wr_reg(sadc_pkg::CTRL0_ADDR, 32'h0);
  endtask : conv
  task automatic tally_and_finish();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd_reg(sadc_pkg::CTRL0_ADDR + 14'(4 * i));
      chk_reg("reset value", 32'h0, v);
    end
    rd_reg(14'h0);
    chk_reg("unmapped", 32'h0, v);
    wr_reg(sadc_pkg::CTRL2_ADDR, 32'hff);
    rd_reg(sadc_pkg::CTRL2_ADDR);
    chk_reg("ctrl2 mask", 32'h17, v);
    $display("test registers done");
    for (int k = 0; k < 8; k++) conv(3'(k), k >= 6);
    for (int i = 0; i < 8; i++) begin
      rd_reg(sadc_pkg::RESULT_ADDR + 14'(4 * i));
      chk_reg("result bank", 32'(res_m[i]), v);
    end
    $display("test conversions done");
    wr_reg(sadc_pkg::CTRL0_ADDR, 32'h42);
    repeat (5) @(posedge clk);
    wr_reg(sadc_pkg::CTRL0_ADDR, 32'h02);
    wait_irq(800);
    chk_reg("halt irq", 0, conv_irq);
    $display("test halt done");
    tally_and_finish();
  end
  initial begin
    #2000000;
    failures++;
    tally_and_finish();
  end
endmodule : sadc_oneshot_tb
`default_nettype wire

// >>> verilog/sadc_oneshot.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_oneshot (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [13:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        ext_trigger_pin,
  input  wire logic [9:0]  conv_data,
  output logic      [4:0]  ain_select,
  output logic             sample_hold_enable,
  output logic             conv_clk_en,
  output logic             sample_strobe,
  output logic             vref_connect,
  output logic             conv_irq
);
  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    logic [7:0]          c0;
    logic [7:0]          c1;
    logic [7:0]          c2;
    logic [7:0][9:0]     res;
    sadc_pkg::sadc_state_t st;
    logic [3:0]          div_cnt;
    logic [5:0]          cyc_cnt;
    logic [2:0]          trg_sync;
    logic                trg_lvl;
    logic [31:0]         rdata;
    logic [4:0]          ain;
    logic                tick;
    logic                samp;
    logic                irq;
  } sadc_reg_t;

  sadc_reg_t r_q;
  sadc_reg_t r_d;

  logic       swtrig;
  logic [5:0] conv_len;
  logic [3:0] div_lim;
  logic [2:0] cks;
  logic       trg_fall;
  logic [2:0] ridx;

  // ************************************************
  // Decode of control fields
  // ************************************************
  always_comb begin
    swtrig = ~r_q.c0[sadc_pkg::C0_TRG];
    case ({r_q.c2[sadc_pkg::C2_SMP], r_q.c1[sadc_pkg::C1_BITS]})
      2'b00:   conv_len = sadc_pkg::CYC_8_NOSH;
      2'b01:   conv_len = sadc_pkg::CYC_10_NOSH;
      2'b10:   conv_len = sadc_pkg::CYC_8_SH;
      default: conv_len = sadc_pkg::CYC_10_SH;
    endcase
    cks = {r_q.c2[sadc_pkg::C2_CLK_DIV_SEL2], r_q.c1[sadc_pkg::C1_CLK_DIV_SEL1], r_q.c0[sadc_pkg::C0_CLK_DIV_SEL0]};
    case (cks)
      3'b000:  div_lim = sadc_pkg::DIV_4;
      3'b001:  div_lim = sadc_pkg::DIV_2;
      3'b010:  div_lim = sadc_pkg::DIV_1;
      3'b011:  div_lim = sadc_pkg::DIV_1;
      3'b100:  div_lim = sadc_pkg::DIV_12;
      3'b101:  div_lim = sadc_pkg::DIV_6;
      default: div_lim = sadc_pkg::DIV_3;
    endcase
    // Change counts only when second and third stages agree
    trg_fall = r_q.trg_lvl & ~r_q.trg_sync[1] & ~r_q.trg_sync[2];
    ridx = addr[sadc_pkg::RES_IDX_LO +: 3];
  end

  // ************************************************
  // Next-state logic
  // ************************************************
  always_comb begin
    r_d = r_q;
    r_d.trg_sync = {r_q.trg_sync[1:0], ext_trigger_pin};
    if (r_q.trg_sync[1] == r_q.trg_sync[2]) begin
      r_d.trg_lvl = r_q.trg_sync[2];
    end
    r_d.irq = 1'b0;
    r_d.samp = 1'b0;
    r_d.rdata = '0;
    r_d.tick = 1'b0;

    // Register writes; control 2 reserved and upper bits forced to 0
    if (wr) begin
      case (addr)
        sadc_pkg::CTRL0_ADDR: r_d.c0 = wdata[7:0];
        sadc_pkg::CTRL1_ADDR: r_d.c1 = wdata[7:0];
        sadc_pkg::CTRL2_ADDR: r_d.c2 = wdata[7:0] & sadc_pkg::CTRL2_WMASK;
        default: ;
      endcase
    end
    if (rd) begin
      if (addr == sadc_pkg::CTRL0_ADDR) begin
        r_d.rdata = {24'h0, r_q.c0};
      end else if (addr == sadc_pkg::CTRL1_ADDR) begin
        r_d.rdata = {24'h0, r_q.c1};
      end else if (addr == sadc_pkg::CTRL2_ADDR) begin
        r_d.rdata = {24'h0, r_q.c2};
      end else if (addr[13:5] == sadc_pkg::RESULT_ADDR[13:5]) begin
        r_d.rdata = {22'h0, r_q.res[ridx]};
      end
    end

    // Pin choice: channel, group, external input; sweep bits unused
    if (r_q.c1[sadc_pkg::C1_OPA_LO +: 2] == sadc_pkg::OPA_EX0) begin
      r_d.ain = sadc_pkg::AIN_EX0;
    end else if (r_q.c1[sadc_pkg::C1_OPA_LO +: 2] == sadc_pkg::OPA_EX1) begin
      r_d.ain = sadc_pkg::AIN_EX1;
    end else begin
      r_d.ain = {r_q.c2[sadc_pkg::C2_GS_LO +: 2], r_q.c0[sadc_pkg::C0_CH_LO +: 3]};
    end

    // Restarts from zero each time, so the first tick is a full period
    // Conversion clock divider runs only while converting
    if (r_q.st == sadc_pkg::ST_CONV) begin
      if (r_q.div_cnt >= div_lim) begin
        r_d.div_cnt = '0;
        r_d.tick = 1'b1;
      end else begin
        r_d.div_cnt = r_q.div_cnt + 4'h1;
      end
    end else begin
      r_d.div_cnt = '0;
    end

    case (r_q.st)
      sadc_pkg::ST_IDLE: begin
        if (r_q.c0[sadc_pkg::C0_START] &&
            r_q.c0[sadc_pkg::C0_MD_LO +: 2] == sadc_pkg::MODE_ONESHOT) begin
          if (swtrig) begin
            r_d.st = sadc_pkg::ST_CONV;
            r_d.cyc_cnt = '0;
          end else begin
            r_d.st = sadc_pkg::ST_ARMED;
          end
        end
      end
      sadc_pkg::ST_ARMED: begin
        if (!r_q.c0[sadc_pkg::C0_START]) begin
          r_d.st = sadc_pkg::ST_IDLE;
        end else if (swtrig) begin
          // Switched to software trigger while armed: start at once
          r_d.st = sadc_pkg::ST_CONV;
          r_d.cyc_cnt = '0;
        end else if (trg_fall) begin
          r_d.st = sadc_pkg::ST_CONV;
          r_d.cyc_cnt = '0;
        end
      end
      sadc_pkg::ST_CONV: begin
        if (!r_q.c0[sadc_pkg::C0_START]) begin
          r_d.st = sadc_pkg::ST_IDLE;
        end else if (!swtrig && trg_fall) begin
          r_d.cyc_cnt = '0;
          r_d.div_cnt = '0;
          // Drop a tick already due, or the restart runs one tick short
          r_d.tick = 1'b0;
        end else if (r_q.tick) begin
          if (r_q.cyc_cnt == conv_len - 6'd1) begin
            r_d.samp = 1'b1;
            r_d.irq = 1'b1;
            r_d.res[r_q.c0[sadc_pkg::C0_CH_LO +: 3]] =
              r_q.c1[sadc_pkg::C1_BITS] ? conv_data : {2'b00, conv_data[9:2]};
            // Pin trigger keeps the flag set so the next edge converts again
            if (swtrig) begin
              r_d.c0[sadc_pkg::C0_START] = 1'b0;
              r_d.st = sadc_pkg::ST_IDLE;
            end else begin
              r_d.st = sadc_pkg::ST_ARMED;
            end
          end else begin
            r_d.cyc_cnt = r_q.cyc_cnt + 6'd1;
          end
        end
      end
      default: r_d.st = sadc_pkg::ST_IDLE;
    endcase
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      r_q <= '0;
      r_q.c0 <= sadc_pkg::CTRL0_RST;
      r_q.c1 <= sadc_pkg::CTRL1_RST;
      r_q.c2 <= sadc_pkg::CTRL2_RST;
      r_q.st <= sadc_pkg::ST_IDLE;
      // Pin idles high; seeding the chain high avoids a false edge
      r_q.trg_sync <= 3'b111;
      r_q.trg_lvl <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign rdata              = r_q.rdata;
  assign ain_select         = r_q.ain;
  assign sample_hold_enable = r_q.c2[sadc_pkg::C2_SMP];
  assign conv_clk_en        = r_q.tick;
  assign sample_strobe      = r_q.samp;
  assign vref_connect       = r_q.c1[sadc_pkg::C1_VCON];
  assign conv_irq           = r_q.irq;

  // ************************************************
  // Assertions
  // ************************************************
  sequence s_sw_start;
    wr && addr == sadc_pkg::CTRL0_ADDR && wdata[sadc_pkg::C0_START]
      && !wdata[sadc_pkg::C0_TRG]
      && wdata[sadc_pkg::C0_MD_LO +: 2] == sadc_pkg::MODE_ONESHOT;
  endsequence
  property p_sw_start;
    @(posedge clk) disable iff (rst)
      s_sw_start |-> ##2 (r_q.st == sadc_pkg::ST_CONV);
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("Start not taken");
  property p_irq_clears;
    @(posedge clk) disable iff (rst)
      (conv_irq && !r_q.c0[sadc_pkg::C0_TRG]) |-> !r_q.c0[sadc_pkg::C0_START];
  endproperty
  a_irq_clears: assert property (p_irq_clears) else $error("Start flag not cleared");
  property p_irq_pulse;
    @(posedge clk) disable iff (rst) conv_irq |=> !conv_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("Irq not a pulse");
  property p_irq_res;
    @(posedge clk) disable iff (rst)
      conv_irq |-> sample_strobe && $past(r_q.st) == sadc_pkg::ST_CONV;
  endproperty
  a_irq_res: assert property (p_irq_res) else $error("Result not with irq");
  property p_busy_flag;
    @(posedge clk) disable iff (rst)
      (r_q.st == sadc_pkg::ST_CONV) |-> r_q.c0[sadc_pkg::C0_START] || $past(wr);
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("Flag low in conversion");
  property p_res2_zero;
    @(posedge clk) disable iff (rst) (r_q.c2 & ~sadc_pkg::CTRL2_WMASK) == 8'h00;
  endproperty
  a_res2_zero: assert property (p_res2_zero) else $error("Reserved bits set");
  property p_min_len;
    @(posedge clk) disable iff (rst)
      $rose(r_q.st == sadc_pkg::ST_CONV) |-> !conv_irq [*8];
  endproperty
  a_min_len: assert property (p_min_len) else $error("Conversion too short");
  property p_len_exact;
    @(posedge clk) disable iff (rst)
      (r_q.st == sadc_pkg::ST_CONV && r_q.tick && r_q.cyc_cnt == conv_len - 6'd1
       && r_q.c0[sadc_pkg::C0_START] && r_q.c0[sadc_pkg::C0_TRG] == 1'b0)
      |=> conv_irq;
  endproperty
  a_len_exact: assert property (p_len_exact) else $error("Completion missed");
  property p_halt;
    @(posedge clk) disable iff (rst)
      (r_q.st != sadc_pkg::ST_IDLE && !r_q.c0[sadc_pkg::C0_START])
      |=> r_q.st == sadc_pkg::ST_IDLE;
  endproperty
  a_halt: assert property (p_halt) else $error("Halt ignored");

  // Control writes mid-conversion are forbidden to software,
  // so these checks do not cover them
  sequence s_ext_edge;
    r_q.st == sadc_pkg::ST_ARMED && r_q.c0[sadc_pkg::C0_START] && !swtrig && trg_fall;
  endsequence
  sequence s_restarted;
    r_q.st == sadc_pkg::ST_CONV && r_q.cyc_cnt == 6'd0 && !conv_clk_en;
  endsequence
  property p_ext_start;
    @(posedge clk) disable iff (rst) s_ext_edge |=> s_restarted;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("Pin edge not taken");
  property p_retrigger;
    @(posedge clk) disable iff (rst)
      (r_q.st == sadc_pkg::ST_CONV && r_q.c0[sadc_pkg::C0_START] && !swtrig && trg_fall)
      |=> s_restarted;
  endproperty
  a_retrigger: assert property (p_retrigger) else $error("Retrigger ignored");
  property p_ext_keep;
    @(posedge clk) disable iff (rst)
      (conv_irq && r_q.c0[sadc_pkg::C0_TRG]) |-> r_q.c0[sadc_pkg::C0_START]
        && r_q.st == sadc_pkg::ST_ARMED;
  endproperty
  a_ext_keep: assert property (p_ext_keep) else $error("Pin trigger not re-armed");
  property p_sw_once;
    @(posedge clk) disable iff (rst)
      (conv_irq && !r_q.c0[sadc_pkg::C0_TRG]) |-> r_q.st == sadc_pkg::ST_IDLE;
  endproperty
  a_sw_once: assert property (p_sw_once) else $error("Converted more than once");
  property p_tick_conv;
    @(posedge clk) disable iff (rst)
      conv_clk_en |-> $past(r_q.st) == sadc_pkg::ST_CONV;
  endproperty
  a_tick_conv: assert property (p_tick_conv) else $error("Tick outside conversion");
  property p_tick_gap;
    @(posedge clk) disable iff (rst)
      (conv_clk_en && div_lim != sadc_pkg::DIV_1)
      |=> !conv_clk_en || div_lim == sadc_pkg::DIV_1;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("Divided ticks adjacent");
  property p_ain_ext;
    @(posedge clk) disable iff (rst)
      (r_q.c1[sadc_pkg::C1_OPA_LO +: 2] == sadc_pkg::OPA_EX0)
      |=> ain_select == sadc_pkg::AIN_EX0;
  endproperty
  a_ain_ext: assert property (p_ain_ext) else $error("External input not chosen");
  property p_res_read;
    @(posedge clk) disable iff (rst)
      (rd && addr[13:5] == sadc_pkg::RESULT_ADDR[13:5])
      |=> rdata == {22'h0, $past(r_q.res[ridx])};
  endproperty
  a_res_read: assert property (p_res_read) else $error("Result read wrong");
  property p_strobe_irq;
    @(posedge clk) disable iff (rst) sample_strobe |-> conv_irq;
  endproperty
  a_strobe_irq: assert property (p_strobe_irq) else $error("Strobe without irq");
endmodule : sadc_oneshot
`default_nettype wire

// >>> verilog/sadc_pkg.sv
`default_nettype none
package sadc_pkg;
  // ************************************************
  // Register map (index = printed offset, byte = 4x)
  // ************************************************
  localparam logic [11:0] ADC_CONTROL_0_IDX = 12'h3d6;
  localparam logic [11:0] ADC_CONTROL_1_IDX = 12'h3d7;
  localparam logic [11:0] ADC_CONTROL_2_IDX = 12'h3d8;
  localparam logic [11:0] RESULT_BASE_IDX   = 12'h3c0;
  localparam int          ADDR_W            = 14;
  localparam logic [13:0] CTRL0_ADDR  = {ADC_CONTROL_0_IDX, 2'b00};
  localparam logic [13:0] CTRL1_ADDR  = {ADC_CONTROL_1_IDX, 2'b00};
  localparam logic [13:0] CTRL2_ADDR  = {ADC_CONTROL_2_IDX, 2'b00};
  localparam logic [13:0] RESULT_ADDR = {RESULT_BASE_IDX, 2'b00};
  localparam logic [7:0]  CTRL0_RST   = 8'h00;
  localparam logic [7:0]  CTRL1_RST   = 8'h00;
  localparam logic [7:0]  CTRL2_RST   = 8'h00;
  localparam logic [7:0]  CTRL2_WMASK = 8'h17;
  // ************************************************
  // Field positions
  // ************************************************
  localparam int C0_CH_LO = 0;
  localparam int C0_MD_LO = 3;
  localparam int C0_TRG   = 5;
  localparam int C0_START = 6;
  localparam int C0_CLK_DIV_SEL0  = 7;
  localparam int C1_MD2   = 2;
  localparam int C1_BITS  = 3;
  localparam int C1_CLK_DIV_SEL1  = 4;
  localparam int C1_VCON  = 5;
  localparam int C1_OPA_LO = 6;
  localparam int C2_SMP   = 0;
  localparam int C2_GS_LO = 1;
  localparam int C2_CLK_DIV_SEL2  = 4;
  localparam logic [1:0] MODE_ONESHOT = 2'b00;
  localparam logic [1:0] GRP_A = 2'b00;
  localparam logic [1:0] GRP_B = 2'b10;
  localparam logic [1:0] OPA_EX0 = 2'b01;
  localparam logic [1:0] OPA_EX1 = 2'b10;
  localparam logic [4:0] AIN_EX0 = 5'h18;
  localparam logic [4:0] AIN_EX1 = 5'h19;
  localparam int RES_IDX_LO = 2;
  // ************************************************
  // Conversion lengths in conversion-clock cycles
  // ************************************************
  localparam logic [5:0] CYC_8_NOSH  = 6'd49;
  localparam logic [5:0] CYC_10_NOSH = 6'd59;
  localparam logic [5:0] CYC_8_SH    = 6'd28;
  localparam logic [5:0] CYC_10_SH   = 6'd33;
  localparam logic [3:0] DIV_1  = 4'h0;
  localparam logic [3:0] DIV_2  = 4'h1;
  localparam logic [3:0] DIV_3  = 4'h2;
  localparam logic [3:0] DIV_4  = 4'h3;
  localparam logic [3:0] DIV_6  = 4'h5;
  localparam logic [3:0] DIV_12 = 4'hb;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} sadc_state_t;
endpackage : sadc_pkg
`default_nettype wire
